// ### core/dac_adc_data_registers.sv
`timescale 1ns/1ns
module dac_adc_data_registers (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic adc_busy_i,
  input wire logic [11:0] adc_data_i,
  input wire logic dac_load_strobe_i,
  input wire logic [11:0] temp_trim_i,
  output logic [11:0] dac_code_o,
  output logic irq_o
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Byte-lane merge into a 12-bit field; lanes above bit 11 are dropped
  function automatic logic [11:0] merge12(input logic [11:0] old_v,
                                          input logic [31:0] d,
                                          input logic [3:0] s);
    logic [11:0] r;
    r = old_v;
    if (s[0]) begin
      r[7:0] = d[7:0];
    end
    if (s[1]) begin
      r[11:8] = d[11:8];
    end
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Wishbone slave
  // ---------------------------------------------------------------
  logic ack_r;
  logic [31:0] dat_r;
  wire req = cyc_i & stb_i;
  wire [5:0] idx = adr_i[7:2];
  // Side effects happen only on the edge where ack is seen high
  wire take = req & ack_r;
  wire wr = take & we_i;
  wire rd = take & ~we_i;
  wire first = req & ~ack_r;

  wire hit_sel = idx == dac_adc_pkg::IDX_LOAD_SEL;
  wire hit_in = idx == dac_adc_pkg::IDX_DAC_IN;
  wire hit_out = idx == dac_adc_pkg::IDX_DAC_OUT;
  wire hit_adc = idx == dac_adc_pkg::IDX_ADC;
  wire hit_temp = idx == dac_adc_pkg::IDX_TEMP;
  wire hit_en = idx == dac_adc_pkg::IDX_IRQ_EN;
  wire hit_stat = idx == dac_adc_pkg::IDX_STATUS;
  wire hit_clr = idx == dac_adc_pkg::IDX_IRQ_CLR;

  wire wr_sel = wr & hit_sel & sel_i[0];
  wire wr_in = wr & hit_in & (sel_i[0] | sel_i[1]);
  wire wr_out = wr & hit_out & (sel_i[0] | sel_i[1]);
  wire wr_en = wr & hit_en & sel_i[0];
  wire wr_clr = wr & hit_clr & sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= first;
    end
  end

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [2:0] mode_r;
  logic [11:0] in_r;
  logic [11:0] out_r;
  logic [11:0] adc_r;
  logic [15:0] temp_r;
  logic sq_sel_in_r;
  logic [11:0] dac_code_r;

  wire load_rise;
  wire load_fall;
  wire busy_rise_unused;
  wire busy_fall;

  edge_detect u_load_edge (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sig_i(dac_load_strobe_i),
    .rise_o(load_rise),
    .fall_o(load_fall)
  );

  edge_detect u_busy_edge (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sig_i(adc_busy_i),
    .rise_o(busy_rise_unused),
    .fall_o(busy_fall)
  );

  // ---------------------------------------------------------------
  // DAC path
  // ---------------------------------------------------------------
  wire sq = mode_r == dac_adc_pkg::LD_SQUARE;
  wire mode_wr = (mode_r == dac_adc_pkg::LD_WRITE) | (mode_r == dac_adc_pkg::LD_WRITE_ALT);
  wire copy_rise = (mode_r == dac_adc_pkg::LD_RISE) & load_rise;
  wire copy_fall = (mode_r == dac_adc_pkg::LD_FALL) & load_fall;
  wire copy_wr = mode_wr & wr_in;
  wire copy = copy_rise | copy_fall | copy_wr;

  wire [11:0] in_nxt = wr_in ? merge12(in_r, dat_i, sel_i) : in_r;
  // A hardware copy wins over a direct write in the same cycle
  wire [11:0] out_nxt = copy ? in_nxt :
                        wr_out ? merge12(out_r, dat_i, sel_i) : out_r;
  // Square mode starts on the output word until the first strobe fall
  wire sq_sel_in_nxt = ~sq ? 1'b0 :
                       load_fall ? 1'b1 :
                       load_rise ? 1'b0 : sq_sel_in_r;
  wire [11:0] code_nxt = (sq & sq_sel_in_nxt) ? in_nxt : out_nxt;
  wire [2:0] mode_nxt = wr_sel ? dat_i[dac_adc_pkg::LOAD_SEL_LSB +: 3] : mode_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r <= dac_adc_pkg::LOAD_SEL_RST;
      in_r <= dac_adc_pkg::WORD_RST[11:0];
      out_r <= dac_adc_pkg::WORD_RST[11:0];
      sq_sel_in_r <= 1'b0;
      dac_code_r <= dac_adc_pkg::WORD_RST[11:0];
    end else begin
      mode_r <= mode_nxt;
      in_r <= in_nxt;
      out_r <= out_nxt;
      sq_sel_in_r <= sq_sel_in_nxt;
      dac_code_r <= code_nxt;
    end
  end

  // ---------------------------------------------------------------
  // ADC capture and temperature offset
  // ---------------------------------------------------------------
  // Offset follows the trim after release; it is never bus-writable
  wire [15:0] temp_nxt = {{4{temp_trim_i[11]}}, temp_trim_i};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      adc_r <= dac_adc_pkg::WORD_RST[11:0];
      temp_r <= dac_adc_pkg::WORD_RST;
    end else begin
      temp_r <= temp_nxt;
      if (busy_fall) begin
        adc_r <= adc_data_i;
      end
    end
  end

  // ---------------------------------------------------------------
  // Flags and interrupt
  // ---------------------------------------------------------------
  wire [1:0] status;
  wire [1:0] enable;
  wire ready = status[dac_adc_pkg::READY_BIT - dac_adc_pkg::FLAG_LSB];
  wire overrun = status[dac_adc_pkg::OVERRUN_BIT - dac_adc_pkg::FLAG_LSB];
  wire [1:0] clr_bits = wr_clr ? dat_i[dac_adc_pkg::FLAG_LSB +: 2] : 2'h0;
  wire ready_clr = (rd & hit_adc) | clr_bits[0];
  wire [1:0] flag_set = {busy_fall & ready, busy_fall};

  irq_flags u_flags (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(flag_set),
    .clr_i({clr_bits[1], ready_clr}),
    .en_wr_i(wr_en),
    .en_data_i(dat_i[dac_adc_pkg::FLAG_LSB +: 2]),
    .status_o(status),
    .enable_o(enable),
    .irq_o(irq_o)
  );

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  // Reserved bits, the clear register and unmapped words read zero
  wire [15:0] rd_word =
    hit_sel ? {9'h000, mode_r, 4'h0} :
    hit_in ? {4'h0, in_r} :
    hit_out ? {4'h0, out_r} :
    hit_adc ? {4'h0, adc_r} :
    hit_temp ? temp_r :
    hit_en ? {13'h0000, enable, 1'b0} :
    hit_stat ? {13'h0000, status, 1'b0} :
    16'h0000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_r <= 32'h0000_0000;
    end else if (first) begin
      dat_r <= {16'h0000, rd_word};
    end
  end

  assign ack_o = ack_r;
  assign dat_o = dat_r;
  assign dac_code_o = dac_code_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence sq_fall_s;
    sq && load_fall;
  endsequence

  sequence sq_rise_s;
    sq && load_rise && !load_fall;
  endsequence

  a_bus_ack_timing: assert property (@(posedge clk_i) disable iff (rst_i)
    first |=> ack_o ##1 !ack_o)
    else $error("ack not given one cycle after request");

  a_reserved_read_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    first && !we_i && (hit_in || hit_out || hit_adc) |=> dat_o[31:12] == 20'h00000)
    else $error("reserved data bits not zero");

  a_copy_on_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_in && mode_wr |=> out_r == in_r)
    else $error("output word missed copy on input write");

  a_no_stray_copy: assert property (@(posedge clk_i) disable iff (rst_i)
    !copy_rise && !copy_fall && !copy_wr && !wr_out |=> $stable(out_r))
    else $error("output word changed without a load event");

  a_code_tracks_out: assert property (@(posedge clk_i) disable iff (rst_i)
    !sq |=> dac_code_o == out_r)
    else $error("converter code differs from output word");

  a_square_fall_in: assert property (@(posedge clk_i) disable iff (rst_i)
    sq_fall_s |=> dac_code_o == in_r)
    else $error("square mode fall did not select input word");

  a_square_rise_out: assert property (@(posedge clk_i) disable iff (rst_i)
    sq_rise_s ##1 (sq && !load_fall) |-> dac_code_o == out_r)
    else $error("square mode rise did not select output word");

  a_adc_capture: assert property (@(posedge clk_i) disable iff (rst_i)
    busy_fall |=> adc_r == $past(adc_data_i))
    else $error("result not captured on busy fall");

  a_adc_write_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && (hit_adc || hit_temp) && !busy_fall |=> $stable(adc_r))
    else $error("write changed the result word");

  a_temp_sign_ext: assert property (@(posedge clk_i) disable iff (rst_i)
    temp_r[15:12] == {4{temp_r[11]}})
    else $error("offset upper bits are not sign copies");

  a_ready_cleared: assert property (@(posedge clk_i) disable iff (rst_i)
    rd && hit_adc && !busy_fall |=> !ready)
    else $error("ready flag not cleared by result read");

  a_overrun_set: assert property (@(posedge clk_i) disable iff (rst_i)
    busy_fall && ready |=> overrun && ready)
    else $error("overrun not flagged on unread result");

  a_reset_clears: assert property (@(posedge clk_i) disable iff (1'b0)
    rst_i |=> in_r == 12'h000 && out_r == 12'h000 && adc_r == 12'h000
              && temp_r == 16'h0000)
    else $error("data words not cleared by reset");

endmodule

// ### core/dac_adc_pkg.sv
package dac_adc_pkg;

  // ---------------------------------------------------------------
  // Word widths
  // ---------------------------------------------------------------
  localparam int DATA_W = 12;
  localparam int REG_W = 16;
  localparam int IDX_W = 6;
  localparam int FLAG_W = 2;

  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [5:0] IDX_LOAD_SEL = 6'h03;
  localparam logic [5:0] IDX_DAC_IN = 6'h04;
  localparam logic [5:0] IDX_DAC_OUT = 6'h05;
  localparam logic [5:0] IDX_ADC = 6'h08;
  localparam logic [5:0] IDX_TEMP = 6'h09;
  localparam logic [5:0] IDX_IRQ_EN = 6'h0a;
  localparam logic [5:0] IDX_STATUS = 6'h0b;
  localparam logic [5:0] IDX_IRQ_CLR = 6'h0d;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int LOAD_SEL_LSB = 4;
  localparam int READY_BIT = 1;
  localparam int OVERRUN_BIT = 2;
  localparam int FLAG_LSB = 1;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [2:0] LOAD_SEL_RST = 3'h0;
  localparam logic [1:0] FLAG_RST = 2'h0;

  // ---------------------------------------------------------------
  // Load-select codes
  // ---------------------------------------------------------------
  localparam logic [2:0] LD_RISE = 3'h0;
  localparam logic [2:0] LD_WRITE = 3'h1;
  localparam logic [2:0] LD_WRITE_ALT = 3'h3;
  localparam logic [2:0] LD_FALL = 3'h4;
  localparam logic [2:0] LD_SQUARE = 3'h5;

endpackage

// ### core/edge_detect.sv
`timescale 1ns/1ns
module edge_detect (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sig_i,
  output logic rise_o,
  output logic fall_o
);

  logic prev_r;

  // Previous level resets low, so a line held high at release reads as a rise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= sig_i;
    end
  end

  assign rise_o = sig_i & ~prev_r;
  assign fall_o = ~sig_i & prev_r;

endmodule

// ### core/irq_flags.sv
`timescale 1ns/1ns
module irq_flags (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] set_i,
  input wire logic [1:0] clr_i,
  input wire logic en_wr_i,
  input wire logic [1:0] en_data_i,
  output logic [1:0] status_o,
  output logic [1:0] enable_o,
  output logic irq_o
);

  logic [1:0] status_r;
  logic [1:0] enable_r;
  wire [1:0] status_nxt = set_i | (status_r & ~clr_i);

  // Set beats clear so an event landing on the clear cycle is kept
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_r <= dac_adc_pkg::FLAG_RST;
      enable_r <= dac_adc_pkg::FLAG_RST;
    end else begin
      status_r <= status_nxt;
      if (en_wr_i) begin
        enable_r <= en_data_i;
      end
    end
  end

  assign status_o = status_r;
  assign enable_o = enable_r;
  assign irq_o = |(status_r & enable_r);

endmodule

// ### test/converter_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Converter side: busy pulse of chosen length, result valid briefly
// ----------------------------------------------------------------
module converter_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [3:0] conv_len_i,
  input wire logic [11:0] value_i,
  output logic adc_busy_o,
  output logic [11:0] adc_data_o
);
  logic [3:0] cnt_r;
  logic [2:0] hold_r;
  logic [11:0] val_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= 4'h0;
      hold_r <= 3'h0;
      val_r <= 12'h000;
    end else if (start_i) begin
      cnt_r <= conv_len_i;
      val_r <= value_i;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
      hold_r <= 3'h4;
    end else if (hold_r != 3'h0) begin
      hold_r <= hold_r - 3'h1;
    end
  end
  assign adc_busy_o = (cnt_r != 4'h0);
  // Outside the hold time the lines show the inverse, so a late sample is caught
  assign adc_data_o = (hold_r != 3'h0) ? val_r : ~val_r;
endmodule

// ### test/tb_top.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat_w = 32'h0;
  logic [3:0] sel = 4'h0;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic strobe = 1'b0;
  logic start = 1'b0;
  logic [3:0] clen = 4'h2;
  logic [11:0] aval = 12'h000;
  logic [11:0] trim = 12'h8f3;
  logic [31:0] dat_o;
  logic ack_o;
  logic adc_busy;
  logic irq_o;
  logic [11:0] adc_data;
  logic [11:0] dac_code_o;
  logic [31:0] seed = 32'h656bce31;
  logic [31:0] expq[$];
  logic [31:0] got;
  logic [15:0] v;
  logic [15:0] w;
  logic [15:0] outw;
  logic [2:0] modes [5] = '{dac_adc_pkg::LD_RISE, dac_adc_pkg::LD_FALL, dac_adc_pkg::LD_WRITE,
                            dac_adc_pkg::LD_WRITE_ALT, 3'h2};
  int fails = 0;
  int samples_checked = 0;

  always #5 clk_i = ~clk_i;

  dac_adc_data_registers u_dac_adc_data_registers (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr),
    .dat_i(dat_w), .sel_i(sel), .we_i(we), .cyc_i(cyc), .stb_i(stb), .dat_o(dat_o),
    .ack_o(ack_o), .adc_busy_i(adc_busy), .adc_data_i(adc_data), .dac_load_strobe_i(strobe),
    .temp_trim_i(trim), .dac_code_o(dac_code_o), .irq_o(irq_o));
  converter_model u_converter_model (.clk_i(clk_i), .rst_i(rst_i), .start_i(start),
    .conv_len_i(clen), .value_i(aval), .adc_busy_o(adc_busy), .adc_data_o(adc_data));

  // ----------------------------------------------------------------
  // Bus, converter and helper tasks
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wb(input logic w_en, input logic [5:0] idx, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w_en;
    adr <= {idx, 2'b00};
    dat_w <= {16'h0000, d};
    sel <= 4'h3;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 40);
    if (n >= 40) fails++;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] idx, input logic [15:0] d);
    wb(1'b1, idx, d);
  endtask
  task automatic rd(input logic [5:0] idx, input logic [15:0] e);
    expq.push_back({16'h0000, e});
    wb(1'b0, idx, 16'h0000);
  endtask
  task automatic rnd(output logic [15:0] r);
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    r = seed[15:0];
  endtask
  task automatic conv(input logic [3:0] n, input logic [11:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    start <= 1'b1;
    clen <= n;
    aval <= d;
    @(posedge clk_i);
    start <= 1'b0;
    do begin
      @(posedge clk_i);
      k++;
    end while (adc_busy !== 1'b0 && k < 40);
    tick(3);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Read results are judged against the oldest note
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we === 1'b0) begin
      if (expq.size() == 0) begin
        fails++;
        $display("Error read note expected one seen none");
      end else begin
        got = expq.pop_front();
        `CHK("read data", got, dat_o)
      end
    end
  end

  initial begin
    tick(5000);
    fails++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    tick(16);
    rst_i <= 1'b0;
    tick(1);
    `CHK("dac code", 12'h000, dac_code_o)
    rd(dac_adc_pkg::IDX_ADC, 16'h0000);
    rd(dac_adc_pkg::IDX_TEMP, {{4{trim[11]}}, trim});
    $display("test reset done");
    rnd(v);
    wr(dac_adc_pkg::IDX_DAC_IN, v);
    rd(dac_adc_pkg::IDX_DAC_IN, {4'h0, v[11:0]});
    rnd(w);
    wr(dac_adc_pkg::IDX_DAC_OUT, w);
    outw = {4'h0, w[11:0]};
    rd(dac_adc_pkg::IDX_DAC_OUT, outw);
    `CHK("dac code", outw[11:0], dac_code_o)
    wr(dac_adc_pkg::IDX_ADC, 16'hffff);
    wr(dac_adc_pkg::IDX_TEMP, 16'h0000);
    rd(dac_adc_pkg::IDX_ADC, 16'h0000);
    rd(dac_adc_pkg::IDX_TEMP, {{4{trim[11]}}, trim});
    rd(6'h3f, 16'h0000);
    $display("test access done");
    foreach (modes[i]) begin
      strobe <= (modes[i] == dac_adc_pkg::LD_FALL);
      tick(3);
      wr(dac_adc_pkg::IDX_LOAD_SEL, {9'h000, modes[i], 4'h0});
      rnd(v);
      wr(dac_adc_pkg::IDX_DAC_IN, v);
      if (modes[i] == dac_adc_pkg::LD_WRITE || modes[i] == dac_adc_pkg::LD_WRITE_ALT)
        outw = {4'h0, v[11:0]};
      tick(2);
      `CHK("dac code before strobe", outw[11:0], dac_code_o)
      strobe <= ~strobe;
      tick(3);
      if (modes[i] == dac_adc_pkg::LD_RISE || modes[i] == dac_adc_pkg::LD_FALL)
        outw = {4'h0, v[11:0]};
      `CHK("dac code after strobe", outw[11:0], dac_code_o)
      rd(dac_adc_pkg::IDX_DAC_OUT, outw);
    end
    $display("test load modes done");
    rnd(w);
    wr(dac_adc_pkg::IDX_DAC_OUT, w);
    rnd(v);
    wr(dac_adc_pkg::IDX_DAC_IN, v);
    wr(dac_adc_pkg::IDX_LOAD_SEL, {9'h000, dac_adc_pkg::LD_SQUARE, 4'h0});
    strobe <= 1'b0;
    tick(3);
    `CHK("square low", v[11:0], dac_code_o)
    strobe <= 1'b1;
    tick(3);
    `CHK("square high", w[11:0], dac_code_o)
    rd(dac_adc_pkg::IDX_DAC_OUT, {4'h0, w[11:0]});
    $display("test square done");
    wr(dac_adc_pkg::IDX_IRQ_EN, 16'h0006);
    rnd(v);
    conv(4'h2, v[11:0]);
    `CHK("irq", 1'b1, irq_o)
    rd(dac_adc_pkg::IDX_STATUS, 16'h0002);
    rnd(w);
    conv(4'h9, w[11:0]);
    rd(dac_adc_pkg::IDX_STATUS, 16'h0006);
    rd(dac_adc_pkg::IDX_ADC, {4'h0, w[11:0]});
    rd(dac_adc_pkg::IDX_STATUS, 16'h0004);
    wr(dac_adc_pkg::IDX_IRQ_EN, 16'h0002);
    tick(1);
    `CHK("irq masked", 1'b0, irq_o)
    wr(dac_adc_pkg::IDX_IRQ_CLR, 16'h0004);
    rd(dac_adc_pkg::IDX_STATUS, 16'h0000);
    $display("test converter done");
    rst_i <= 1'b1;
    tick(2);
    rst_i <= 1'b0;
    tick(1);
    `CHK("dac code", 12'h000, dac_code_o)
    rd(dac_adc_pkg::IDX_DAC_IN, 16'h0000);
    rd(dac_adc_pkg::IDX_DAC_OUT, 16'h0000);
    rd(dac_adc_pkg::IDX_ADC, 16'h0000);
    $display("test second reset done");
    tick(2);
    report_and_stop();
  end
endmodule
